//--- hw/lwr_pkg.sv
package lwr_pkg;

	// ==========================================
	// register map (byte addresses)
	localparam logic [3:0] LWR_OFS_CTRL = 4'h0;
	localparam logic [3:0] LWR_OFS_RESTART = 4'h4;
	localparam logic [3:0] LWR_OFS_STATUS = 4'h8;

	// ==========================================
	// field layout
	localparam int LWR_SEL_W = 3;
	localparam int LWR_CTRL_SEL_LSB = 0;
	localparam int LWR_CTRL_EN_BIT = 4;
	localparam int LWR_CTRL_LOCK_BIT = 5;
	localparam int LWR_STAT_CNT_LSB = 0;
	localparam int LWR_STAT_RUN_BIT = 16;
	localparam int LWR_STAT_LOCK_BIT = 17;

	// ==========================================
	// counter and reset values
	localparam int LWR_CNT_W = 16;
	localparam logic [LWR_SEL_W-1:0] LWR_SEL_RST = 3'h7;
	localparam logic [LWR_CNT_W-1:0] LWR_CNT_RST = 16'h0000;
	localparam logic [31:0] LWR_DATA_ZERO = 32'h0000_0000;
	localparam int LWR_TO_BASE_DEF = 6;

	// ==========================================
	// types
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} lwr_avs_req_t;

	typedef enum logic [2:0] {
		LWR_ST_OFF = 3'b001,
		LWR_ST_RUN = 3'b010,
		LWR_ST_LOCK = 3'b100
	} lwr_state_t;

	// ==========================================
	// terminal count: 2^(base+sel) ticks per interval
	function automatic logic [LWR_CNT_W-1:0] lwr_term(input logic [LWR_SEL_W-1:0] sel, input int base);
		int sh;
		sh = base + int'(sel);
		return LWR_CNT_W'((32'h1 << sh) - 32'h1);
	endfunction : lwr_term

endpackage : lwr_pkg

//--- hw/lwr_watchdog.sv
// What this block does
// [RULE1] the supervisor count advances only on edges of the low-frequency oscillator, not on clk.
// [RULE2] when the count passes its terminal value the block requests a full system reset.
// [RULE3] software has to restart the count before the chosen interval runs out, or the reset follows.
// [RULE4] after any reset the supervisor runs at once with the longest interval selected.
// [RULE5] software can switch counting off, and no overflow reset happens while it is off and unlocked.
// [RULE6] once locked, any attempt to switch the supervisor off is ignored until the next system reset.
// [RULE7] while locked, the interval selection cannot be changed either until a system reset.
// [RULE8] the overflow reset acts only inside the chip and never drives the external reset pin.
// [RULE9] software picks the interval from eight lengths of doubling size.
// [RULE10] a restart clears the count to zero so that a whole interval starts again.
`timescale 1ns/100ps
module lwr_watchdog #(
	parameter int TO_BASE = lwr_pkg::LWR_TO_BASE_DEF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic lfosc_clk,
	input wire lwr_pkg::lwr_avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic sys_reset_req
);
	import lwr_pkg::*;

	// ==========================================
	// reset release
	logic rst_s1_r;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// ==========================================
	// oscillator edge detect
	logic lf_s1_r;
	logic lf_s2_r;
	logic lf_s3_r;
	logic [2:0] lf_arm_r;
	logic [2:0] lf_arm_nxt;
	logic tick;

	// hold off edges until the delay stage carries a real oscillator sample
	always_comb begin
		lf_arm_nxt = {lf_arm_r[1:0], 1'b1};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lf_s1_r <= 1'b0;
			lf_s2_r <= 1'b0;
			lf_s3_r <= 1'b0;
			lf_arm_r <= 3'h0;
		end else begin
			lf_s1_r <= lfosc_clk;
			lf_s2_r <= lf_s1_r;
			lf_s3_r <= lf_s2_r;
			lf_arm_r <= lf_arm_nxt;
		end
	end

	assign tick = lf_s2_r & ~lf_s3_r & lf_arm_r[2]; // see [RULE1]

	// ==========================================
	// bus handshake
	logic ack_r;
	logic ack_nxt;
	logic req_any;
	logic acc;
	logic wr_ctrl;
	logic wr_restart;
	logic [LWR_SEL_W-1:0] wsel;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	assign req_any = avs_req.read | avs_req.write;
	assign acc = req_any & ack_r;
	assign avs_waitrequest = req_any & ~ack_r;
	assign wr_ctrl = acc & avs_req.write & (avs_req.address == LWR_OFS_CTRL);
	assign wr_restart = acc & avs_req.write & (avs_req.address == LWR_OFS_RESTART);
	assign wsel = avs_req.writedata[LWR_CTRL_SEL_LSB +: LWR_SEL_W];
	assign avs_readdata = rdata_r;

	// ==========================================
	// mode and interval
	lwr_state_t st_r;
	lwr_state_t st_nxt;
	logic [LWR_SEL_W-1:0] sel_r;
	logic [LWR_SEL_W-1:0] sel_nxt;
	logic running;

	assign running = (st_r != LWR_ST_OFF);

	always_comb begin
		st_nxt = st_r;
		sel_nxt = sel_r;
		case (st_r)
			LWR_ST_OFF, LWR_ST_RUN: begin
				if (wr_ctrl) begin
					sel_nxt = wsel; // see [RULE9]
					if (avs_req.writedata[LWR_CTRL_LOCK_BIT]) begin
						st_nxt = LWR_ST_LOCK;
					end else if (avs_req.writedata[LWR_CTRL_EN_BIT]) begin
						st_nxt = LWR_ST_RUN;
					end else begin
						st_nxt = LWR_ST_OFF; // see [RULE5]
					end
				end
			end
			LWR_ST_LOCK: begin
				st_nxt = LWR_ST_LOCK; // see [RULE6] [RULE7]
			end
			default: begin
				st_nxt = LWR_ST_RUN;
			end
		endcase
	end

	// ==========================================
	// counter and overflow
	logic [LWR_CNT_W-1:0] cnt_r;
	logic [LWR_CNT_W-1:0] cnt_nxt;
	logic [LWR_CNT_W-1:0] term;
	logic ovf_r;
	logic ovf_nxt;

	assign term = lwr_term(sel_r, TO_BASE);

	always_comb begin
		cnt_nxt = cnt_r;
		ovf_nxt = 1'b0;
		if (!running || wr_restart) begin
			cnt_nxt = LWR_CNT_RST; // see [RULE10] [RULE5]
		end else if (tick) begin
			if (cnt_r >= term) begin
				cnt_nxt = LWR_CNT_RST;
				ovf_nxt = 1'b1; // see [RULE2] [RULE3]
			end else begin
				cnt_nxt = cnt_r + 16'h0001; // see [RULE1]
			end
		end
	end

	// internal reset request only; no pin drive exists here
	assign sys_reset_req = ovf_r; // see [RULE8]

	// ==========================================
	// read data
	always_comb begin
		rdata_nxt = rdata_r;
		ack_nxt = req_any & ~ack_r;
		if (avs_req.read && !ack_r) begin
			rdata_nxt = LWR_DATA_ZERO;
			case (avs_req.address)
				LWR_OFS_CTRL: begin
					rdata_nxt[LWR_CTRL_SEL_LSB +: LWR_SEL_W] = sel_r;
					rdata_nxt[LWR_CTRL_EN_BIT] = running;
					rdata_nxt[LWR_CTRL_LOCK_BIT] = (st_r == LWR_ST_LOCK);
				end
				LWR_OFS_STATUS: begin
					rdata_nxt[LWR_STAT_CNT_LSB +: LWR_CNT_W] = cnt_r;
					rdata_nxt[LWR_STAT_RUN_BIT] = running;
					rdata_nxt[LWR_STAT_LOCK_BIT] = (st_r == LWR_ST_LOCK);
				end
				default: begin
					rdata_nxt = LWR_DATA_ZERO;
				end
			endcase
		end
	end

	// ==========================================
	// state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= LWR_ST_RUN; // see [RULE4]
			sel_r <= LWR_SEL_RST; // see [RULE4]
			cnt_r <= LWR_CNT_RST;
			ovf_r <= 1'b0;
			ack_r <= 1'b0;
			rdata_r <= LWR_DATA_ZERO;
		end else begin
			st_r <= st_nxt;
			sel_r <= sel_nxt;
			cnt_r <= cnt_nxt;
			ovf_r <= ovf_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================
	// assertions
	property p_ovf_fires;
		@(posedge clk) disable iff (!rst_n)
		(running && tick && !wr_restart && cnt_r >= term) |=> (sys_reset_req && cnt_r == LWR_CNT_RST);
	endproperty
	a_ovf_fires: assert property (p_ovf_fires) else $error("overflow did not request reset"); // see [RULE2]

	property p_restart_clears;
		@(posedge clk) disable iff (!rst_n)
		wr_restart |=> (cnt_r == LWR_CNT_RST && !sys_reset_req);
	endproperty
	a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear count"); // see [RULE10]

	property p_off_no_reset;
		@(posedge clk) disable iff (!rst_n)
		(st_r == LWR_ST_OFF) |=> !sys_reset_req;
	endproperty
	a_off_no_reset: assert property (p_off_no_reset) else $error("reset while disabled"); // see [RULE5]

	property p_lock_holds;
		@(posedge clk) disable iff (!rst_n)
		(st_r == LWR_ST_LOCK) |=> (st_r == LWR_ST_LOCK);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("lock left without reset"); // see [RULE6]

	property p_lock_sel;
		@(posedge clk) disable iff (!rst_n)
		(st_r == LWR_ST_LOCK) |=> $stable(sel_r);
	endproperty
	a_lock_sel: assert property (p_lock_sel) else $error("interval changed while locked"); // see [RULE7]

	property p_lf_only;
		@(posedge clk) disable iff (!rst_n)
		(running && !tick && !wr_restart) |=> $stable(cnt_r);
	endproperty
	a_lf_only: assert property (p_lf_only) else $error("count moved without oscillator edge"); // see [RULE1]

	property p_reset_default;
		@(posedge clk)
		$rose(rst_n) |-> (st_r == LWR_ST_RUN && sel_r == LWR_SEL_RST && cnt_r == LWR_CNT_RST);
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("bad state after reset"); // see [RULE4]

	property p_sel_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_ctrl && st_r != LWR_ST_LOCK) |=> (sel_r == $past(wsel));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("interval write lost"); // see [RULE9]

	property p_one_wait;
		@(posedge clk) disable iff (!rst_n)
		(req_any && !ack_r) |-> avs_waitrequest ##1 (!req_any || !avs_waitrequest);
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("waitrequest not one cycle");

	property p_pulse_one;
		@(posedge clk) disable iff (!rst_n)
		sys_reset_req |=> !sys_reset_req;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("reset request longer than one cycle"); // see [RULE2]

	property p_ovf_tick;
		@(posedge clk) disable iff (!rst_n)
		sys_reset_req |-> $past(tick);
	endproperty
	a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without oscillator edge"); // see [RULE1]

	property p_count_step;
		@(posedge clk) disable iff (!rst_n)
		(running && tick && !wr_restart && cnt_r < term) |=> (cnt_r == $past(cnt_r) + 16'h0001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step on edge"); // see [RULE1]

	property p_off_cnt;
		@(posedge clk) disable iff (!rst_n)
		(st_r == LWR_ST_OFF) |=> (cnt_r == LWR_CNT_RST);
	endproperty
	a_off_cnt: assert property (p_off_cnt) else $error("count moved while disabled"); // see [RULE5]

	property p_disable_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_ctrl && st_r != LWR_ST_LOCK && !avs_req.writedata[LWR_CTRL_LOCK_BIT]
			&& !avs_req.writedata[LWR_CTRL_EN_BIT]) |=> (st_r == LWR_ST_OFF);
	endproperty
	a_disable_write: assert property (p_disable_write) else $error("disable write lost"); // see [RULE5]

	property p_enable_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_ctrl && st_r != LWR_ST_LOCK && !avs_req.writedata[LWR_CTRL_LOCK_BIT]
			&& avs_req.writedata[LWR_CTRL_EN_BIT]) |=> (st_r == LWR_ST_RUN);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // see [RULE5]

	property p_lock_disable;
		@(posedge clk) disable iff (!rst_n)
		(st_r == LWR_ST_LOCK && wr_ctrl) |=> running;
	endproperty
	a_lock_disable: assert property (p_lock_disable) else $error("disabled while locked"); // see [RULE6]

	property p_rd_hold;
		@(posedge clk) disable iff (!rst_n)
		!(avs_req.read && !ack_r) |=> $stable(avs_readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");

	property p_ack_drop;
		@(posedge clk) disable iff (!rst_n)
		acc |=> !ack_r;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("acknowledge held past one transfer");

endmodule : lwr_watchdog

//--- tb/lwr_watchdog_test.sv
`timescale 1ns/100ps
module lwr_watchdog_test;
	import lwr_pkg::*;
	// ==========================================
	// clock, oscillator and pulse monitor
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic lfosc_clk = 1'b0;
	logic lf_en = 1'b1;
	logic [2:0] lf_div = 3'h0;
	lwr_avs_req_t avs_req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sys_reset_req;
	logic [31:0] rd;
	int errors = 0;
	int checks_done = 0;
	int pulses = 0;

	always #25 clk = ~clk;

	always @(posedge clk) begin
		if (lf_en) begin
			lf_div <= lf_div + 3'h1;
			lfosc_clk <= lf_div[2];
		end
		if (sys_reset_req === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	lwr_watchdog #(.TO_BASE(1)) lwr_watchdog_i (
		.clk(clk),
		.arst_n(arst_n),
		.lfosc_clk(lfosc_clk),
		.avs_req(avs_req),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.sys_reset_req(sys_reset_req)
	);

	// ==========================================
	// helpers
	task end_of_test;
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task chk_rng(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_rng

	function automatic logic [31:0] cv(input logic [2:0] s, input logic e, input logic l);
		cv = 32'h0;
		cv[LWR_CTRL_SEL_LSB +: LWR_SEL_W] = s;
		cv[LWR_CTRL_EN_BIT] = e;
		cv[LWR_CTRL_LOCK_BIT] = l;
	endfunction : cv

	task do_reset;
		arst_n <= 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_req <= '{read: ~wr, write: wr, address: a, writedata: d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_req <= '0;
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			end_of_test();
		end
	endtask : bus

	// restart in step with the oscillator, then time the overflow pulse
	task expect_to(input int n);
		int c;
		c = 0;
		while (lfosc_clk !== 1'b1 && c < 20) begin
			@(posedge clk);
			c++;
		end
		while (lfosc_clk !== 1'b0 && c < 40) begin
			@(posedge clk);
			c++;
		end
		if (lfosc_clk !== 1'b0) begin
			errors++;
			end_of_test();
		end
		bus(1'b1, LWR_OFS_RESTART, 32'h0);
		c = 0;
		while (sys_reset_req !== 1'b1 && c < 9000) begin
			@(posedge clk);
			c++;
		end
		chk_rng(c, n * 8 - 6, n * 8 + 2);
		if (c >= 9000) begin
			end_of_test();
		end
	endtask : expect_to

	task no_reset(input int cycles);
		int p;
		p = pulses;
		repeat (cycles) @(posedge clk);
		chk(32'(pulses - p), 32'h0);
	endtask : no_reset

	// ==========================================
	// scenarios
	task t_default;
		bus(1'b0, LWR_OFS_CTRL, 32'h0);
		chk(rd, cv(LWR_SEL_RST, 1'b1, 1'b0));
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0);
		chk(rd, 32'h0);
		expect_to(256);
	endtask : t_default

	task t_disable;
		bus(1'b1, LWR_OFS_CTRL, cv(3'h0, 1'b0, 1'b0));
		no_reset(400);
		bus(1'b0, LWR_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		lf_en <= 1'b0;
		bus(1'b1, LWR_OFS_CTRL, cv(3'h0, 1'b1, 1'b0));
		bus(1'b1, LWR_OFS_RESTART, 32'h0);
		no_reset(400);
		lf_en <= 1'b1;
	endtask : t_disable

	task t_sel;
		int p;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, LWR_OFS_CTRL, cv(3'(s), 1'b1, 1'b0));
			expect_to(2 ** (1 + s));
		end
		@(posedge clk);
		p = pulses;
		for (int i = 0; i < 6; i++) begin
			repeat (90) @(posedge clk);
			bus(1'b1, LWR_OFS_RESTART, 32'h0);
		end
		repeat (90) @(posedge clk);
		chk(32'(pulses - p), 32'h0);
	endtask : t_sel

	task t_lock;
		bus(1'b1, LWR_OFS_RESTART, 32'h0);
		bus(1'b1, LWR_OFS_CTRL, cv(3'h2, 1'b0, 1'b1));
		bus(1'b1, LWR_OFS_CTRL, cv(3'h0, 1'b0, 1'b0));
		bus(1'b0, LWR_OFS_CTRL, 32'h0);
		chk(rd, cv(3'h2, 1'b1, 1'b1));
		bus(1'b0, LWR_OFS_STATUS, 32'h0);
		chk({30'h0, rd[LWR_STAT_LOCK_BIT], rd[LWR_STAT_RUN_BIT]}, 32'h3);
		expect_to(8);
		do_reset();
		bus(1'b0, LWR_OFS_CTRL, 32'h0);
		chk(rd, cv(LWR_SEL_RST, 1'b1, 1'b0));
	endtask : t_lock

	initial begin
		do_reset();
		t_default();
		t_disable();
		t_sel();
		t_lock();
		end_of_test();
	end
endmodule : lwr_watchdog_test
